// [bench/sdb_link_checker.sv]
// Link checker for the SDRAM burst link
`timescale 1ns/1ps
module sdb_link_checker (
   input wire logic                 clk_sys,
   input wire logic                 rst,
   input wire sdb_pkg::sdb_cmd_type cmd,
   input wire logic [1:0]           bank,
   input wire logic [12:0]          addr,
   input wire logic                 devDqOe
);
   import sdb_pkg::*;
   typedef struct packed {
      logic [12:0] mode;
      logic [3:0]  open;
   } sdb_chk_type;
   sdb_chk_type st_ff;
   sdb_chk_type nxt_st;
   logic        lat3;
   //==========================================================
   // Shadow of mode and open rows from link commands; any precharge clears every bank
   always_comb begin
      nxt_st = st_ff;
      if (cmd == CMD_LMR) nxt_st.mode = addr;
      if (cmd == CMD_ACT) nxt_st.open[bank] = 1'h1;
      if (cmd == CMD_PRE) nxt_st.open = 4'h0;
      if (rst) nxt_st = '{MODE_RST, 4'h0};
   end
   always_ff @(posedge clk_sys) st_ff <= nxt_st;
   assign lat3 = st_ff.mode[6:4] == 3'h3;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   //==========================================================
   // Assertions
   lmr_op_mode_a: assert property (cmd == CMD_LMR |->
      addr[8:7] == 2'h0 && addr[12:10] == 3'h0) else $error("bad op mode");
   lmr_length_a: assert property (cmd == CMD_LMR |->
      addr[2:0] <= 3'h3 || (addr[2:0] == 3'h7 && !addr[3]))
      else $error("bad burst length code");
   lmr_latency_a: assert property (cmd == CMD_LMR |->
      addr[6:4] inside {3'h2, 3'h3}) else $error("bad latency code");
   lmr_idle_a: assert property (cmd == CMD_LMR |->
      st_ff.open == 4'h0) else $error("mode load with open bank");
   mrd_gap_a: assert property (cmd == CMD_LMR |=>
      cmd == CMD_NOP) else $error("command right after mode load");
   act_closed_a: assert property (cmd == CMD_ACT |->
      !st_ff.open[bank]) else $error("activate to open bank");
   col_open_a: assert property (cmd inside {CMD_RD, CMD_WR} |->
      st_ff.open[bank]) else $error("column access to closed bank");
   lat_two_a: assert property (cmd == CMD_RD && !lat3 |->
      ##1 !devDqOe ##1 devDqOe) else $error("latency two data late");
   lat_three_a: assert property (cmd == CMD_RD && lat3 |->
      ##2 !devDqOe ##1 devDqOe) else $error("latency three data off");
   cover property (cmd == CMD_LMR);
   cover property (cmd == CMD_RD && lat3);
   cover property (cmd == CMD_WR);
endmodule

// [bench/sdram_burst_mode_and_activation_bench.sv]
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
module sdram_burst_mode_and_activation_bench;
   import sdb_pkg::*;
   typedef struct packed {
      logic [12:0] mode;
      logic [7:0]  col;
      logic [2:0]  n;
      logic [31:0] exp;
   } sdb_row_type;
   // Expected columns are packed first beat highest
   sdb_row_type tbl [7] = '{
      '{13'h0021, 8'h11, 3'h2, 32'h11100000},
      '{13'h0022, 8'h21, 3'h4, 32'h21222320},
      '{13'h003A, 8'h21, 3'h4, 32'h21202322},
      '{13'h0033, 8'h0B, 3'h4, 32'h0B0C0D0E},
      '{13'h002B, 8'h0D, 3'h4, 32'h0D0C0F0E},
      '{13'h0027, 8'hFE, 3'h4, 32'hFEFF0001},
      '{13'h0030, 8'h33, 3'h1, 32'h33000000}};
   logic        clk_sys, rst, awV, wV, bRdy, arV, rRdy;
   logic        awR, wR, bV, arR, rV, memRd, memWr;
   logic [7:0]  awA, arA, memCol;
   logic [31:0] wD, rD, st;
   logic [10:0] memRow;
   logic [1:0]  bRsp, rRsp, rsp;
   int          num_errors, checks_done, wrCnt;
   logic [7:0]  colQ [$];
   sdb_link_if lk ();
   sdb_ctrl sdb_ctrl_inst (.clk_sys(clk_sys), .rst(rst),
      .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR),
      .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV),
      .s_axi_wready(wR), .s_axi_bresp(bRsp), .s_axi_bvalid(bV),
      .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
      .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRsp),
      .s_axi_rvalid(rV), .s_axi_rready(rRdy), .lk(lk.ctrl));
   sdb_device sdb_device_inst (.clk_sys(clk_sys), .rst(rst), .lk(lk.dev),
      .memBank(), .memRow(memRow), .memCol(memCol), .memRd(memRd),
      .memWr(memWr), .memWdata(), .memRdata({5'h0, memRow, 8'h00, memCol}),
      .rowOpen(), .modeWord(), .modeNormal());
   sdb_link_checker sdb_link_checker_inst (.clk_sys(clk_sys), .rst(rst),
      .cmd(lk.cmd), .bank(lk.bank), .addr(lk.addr), .devDqOe(lk.devDqOe));
   // Storage answers with its own column so beat order is visible
   always @(posedge clk_sys) begin
      if (memRd) colQ.push_back(memCol);
      if (memWr) wrCnt++;
   end
   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   //==========================================================
   // Tasks
   task automatic chkV(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One transfer; both channels released only when taken
   task automatic axi(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      logic [3:0] hs;
      hs = 4'h0;
      awA <= a;
      arA <= a;
      wD <= d;
      {awV, wV, bRdy} <= {3{w}};
      {arV, rRdy} <= {2{!w}};
      while (!hs[3]) begin
         @(negedge clk_sys);
         hs = {bV | rV, awR & awV, wR & wV, arR & arV};
         q = w ? 32'h0 : rD;
         rsp = w ? bRsp : rRsp;
         @(posedge clk_sys);
         if (hs[2]) awV <= 1'h0;
         if (hs[1]) wV <= 1'h0;
         if (hs[0]) arV <= 1'h0;
      end
   endtask
   task automatic cmdOp(input logic [2:0] op, input logic [12:0] a);
      axi(1'h1, REG_STATUS, 32'h6, st);
      axi(1'h1, REG_ADDR, {19'h0, a}, st);
      axi(1'h1, REG_CMD, {29'h0, op}, st);
      st = 32'h1;
      while (st[ST_BUSY] !== 1'h0) axi(1'h0, REG_STATUS, 32'h0, st);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge clk_sys);
      num_errors++;
      results();
   end
   //==========================================================
   // Main sequence
   initial begin
      {rst, awV, wV, bRdy, arV, rRdy} = 6'h20;
      {awA, arA, wD} = 48'h0;
      num_errors = 0;
      checks_done = 0;
      wrCnt = 0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'h0;
      @(posedge clk_sys);
      foreach (tbl[i]) begin
         cmdOp(CMD_PRE, 13'h0400);
         cmdOp(CMD_LMR, tbl[i].mode);
         cmdOp(CMD_ACT, 13'h0005);
         colQ.delete();
         axi(1'h1, REG_COUNT, {29'h0, tbl[i].n}, st);
         cmdOp(CMD_RD, {5'h0, tbl[i].col});
         do axi(1'h0, REG_STATUS, 32'h0, st);
         while (st[ST_RDVALID] !== 1'h1);
         axi(1'h0, REG_RDATA, 32'h0, st);
         chkV("first word", {24'h000500, tbl[i].col}, st);
         for (int k = 0; k < tbl[i].n; k++)
            chkV("column", tbl[i].exp[31-8*k-:8], colQ[k]);
         $display("burst row %0d done", i);
      end
      // Reset in mid-run, then refusals and the single write
      rst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      @(posedge clk_sys);
      axi(1'h0, REG_MODE, 32'h0, st);
      chkV("reset mode", 32'h20, st);
      cmdOp(CMD_LMR, 13'h00A2);
      chkV("op mode refused", 32'h1, st[ST_REFUSED]);
      cmdOp(CMD_LMR, 13'h002F);
      chkV("page order refused", 32'h1, st[ST_REFUSED]);
      axi(1'h0, REG_MODE, 32'h0, st);
      chkV("mode kept", 32'h20, st);
      cmdOp(CMD_LMR, 13'h0222);
      axi(1'h1, REG_COUNT, 32'h4, st);
      cmdOp(CMD_ACT, 13'h0005);
      cmdOp(CMD_ACT, 13'h0006);
      chkV("second activate", 32'h1, st[ST_REFUSED]);
      wrCnt = 0;
      cmdOp(CMD_WR, 13'h0040);
      axi(1'h0, 8'h40, 32'h0, st);
      chkV("unmapped resp", 32'h2, rsp);
      chkV("write beats", 32'h1, wrCnt);
      $display("hand tests done");
      results();
   end
endmodule

// [src/sdb_ctrl.sv]
// SDRAM controller end: AXI4-Lite registers, timing guards, sequencing
`timescale 1ns/1ps
module sdb_ctrl (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output      logic         s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output      logic         s_axi_wready,
   output      logic [1:0]   s_axi_bresp,
   output      logic         s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output      logic         s_axi_arready,
   output      logic [31:0]  s_axi_rdata,
   output      logic [1:0]   s_axi_rresp,
   output      logic         s_axi_rvalid,
   input  wire logic         s_axi_rready,
   sdb_link_if.ctrl          lk
);
   import sdb_pkg::*;

   //==========================================================
   // State
   typedef struct packed {
      logic              awHave;
      logic [7:0]        awAddr;
      logic              wHave;
      logic [31:0]       wData;
      logic [3:0]        wStrb;
      logic              bValid;
      logic [1:0]        bResp;
      logic              rValid;
      logic [31:0]       rData;
      logic [1:0]        rResp;
      logic [12:0]       addrReg;
      logic [31:0]       wdataReg;
      logic [7:0]        countReg;
      logic [31:0]       rdataReg;
      logic              rdValid;
      logic              refused;
      logic [12:0]       modeSh;
      logic              pend;
      sdb_cmd_type       pendOp;
      logic [1:0]        pendBank;
      logic [3:0]        open;
      logic [3:0][3:0]   rcd;
      logic [3:0][3:0]   rc;
      logic [3:0]        rrd;
      logic [3:0]        mrd;
      logic [7:0]        beatCnt;
      logic              wrBurst;
      logic [2:0]        capCnt;
      sdb_cmd_type       cmd;
      logic [1:0]        bank;
      logic [12:0]       addrOut;
      logic              dqOe;
   } sdb_ctrl_state_type;

   sdb_ctrl_state_type st_ff;
   sdb_ctrl_state_type nxt_st;
   logic              busy;
   logic [1:0]        b;
   logic [31:0]       wv;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.cmd = CMD_NOP;
      nxt_st.dqOe = 1'b0;
      b = st_ff.pendBank;
      busy = st_ff.pend || st_ff.beatCnt != 8'h00 || st_ff.capCnt != 3'h0;
      for (int i = 0; i < BANKS; i++) begin
         if (st_ff.rcd[i] != 4'h0) nxt_st.rcd[i] = st_ff.rcd[i] - 4'h1;
         if (st_ff.rc[i] != 4'h0) nxt_st.rc[i] = st_ff.rc[i] - 4'h1;
      end
      if (st_ff.rrd != 4'h0) nxt_st.rrd = st_ff.rrd - 4'h1;
      if (st_ff.mrd != 4'h0) nxt_st.mrd = st_ff.mrd - 4'h1;
      //=======================================================
      // AXI4-Lite slave, one write and one read at a time
      wv = st_ff.wData;
      for (int k = 0; k < 4; k++) begin
         if (!st_ff.wStrb[k]) wv[k*8+:8] = 8'h00;
      end
      if (st_ff.bValid && s_axi_bready) nxt_st.bValid = 1'b0;
      if (st_ff.rValid && s_axi_rready) nxt_st.rValid = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.awHave = 1'b1;
         nxt_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.wHave = 1'b1;
         nxt_st.wData = s_axi_wdata;
         nxt_st.wStrb = s_axi_wstrb;
      end
      if (st_ff.awHave && st_ff.wHave) begin
         nxt_st.awHave = 1'b0;
         nxt_st.wHave = 1'b0;
         nxt_st.bValid = 1'b1;
         nxt_st.bResp = RESP_OKAY;
         case (st_ff.awAddr)
            REG_CMD: begin
               if (busy) begin
                  nxt_st.refused = 1'b1;
               end else begin
                  nxt_st.pend = 1'b1;
                  nxt_st.pendOp = sdb_cmd_type'(wv[2:0]);
                  nxt_st.pendBank = wv[CMD_BANK_LSB+:2];
               end
            end
            REG_ADDR:   nxt_st.addrReg = wv[12:0];
            REG_WDATA:  nxt_st.wdataReg = wv;
            REG_COUNT:  nxt_st.countReg = wv[7:0];
            REG_STATUS: begin
               if (wv[ST_REFUSED]) nxt_st.refused = 1'b0;
               if (wv[ST_RDVALID]) nxt_st.rdValid = 1'b0;
            end
            default: nxt_st.bResp = RESP_SLVERR;
         endcase
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rValid = 1'b1;
         nxt_st.rResp = RESP_OKAY;
         case (s_axi_araddr)
            REG_ADDR:   nxt_st.rData = {19'h0000, st_ff.addrReg};
            REG_WDATA:  nxt_st.rData = st_ff.wdataReg;
            REG_COUNT:  nxt_st.rData = {24'h000000, st_ff.countReg};
            REG_STATUS: nxt_st.rData = {29'h0000000, st_ff.rdValid,
                                        st_ff.refused, busy};
            REG_RDATA:  nxt_st.rData = st_ff.rdataReg;
            REG_MODE:   nxt_st.rData = {19'h0000, st_ff.modeSh};
            default: begin
               nxt_st.rData = 32'h00000000;
               nxt_st.rResp = RESP_SLVERR;
            end
         endcase
      end
      //=======================================================
      // Read capture, one clock after the latency expires
      if (st_ff.capCnt != 3'h0) begin
         nxt_st.capCnt = st_ff.capCnt - 3'h1;
         if (st_ff.capCnt == 3'h1) begin
            nxt_st.rdataReg = lk.devDq;
            nxt_st.rdValid = 1'b1;
         end
      end
      //=======================================================
      // Burst continuation and stop
      if (st_ff.beatCnt > 8'h01) begin
         nxt_st.beatCnt = st_ff.beatCnt - 8'h01;
         nxt_st.dqOe = st_ff.wrBurst;
      end else if (st_ff.beatCnt == 8'h01) begin
         nxt_st.cmd = CMD_BST;
         nxt_st.beatCnt = 8'h00;
      end else if (st_ff.pend) begin
         nxt_st.bank = b;
         nxt_st.addrOut = st_ff.addrReg;
         case (st_ff.pendOp)
            CMD_ACT: begin
               if (st_ff.open[b]) begin
                  nxt_st.refused = 1'b1;
                  nxt_st.pend = 1'b0;
               end else if (st_ff.rc[b] == 4'h0 && st_ff.rrd == 4'h0
                            && st_ff.mrd == 4'h0) begin
                  nxt_st.cmd = CMD_ACT;
                  nxt_st.pend = 1'b0;
                  nxt_st.open[b] = 1'b1;
                  nxt_st.rcd[b] = 4'(RCD_CYC - 1);
                  nxt_st.rc[b] = 4'(RC_CYC - 1);
                  nxt_st.rrd = 4'(RRD_CYC - 1);
               end
            end
            CMD_RD, CMD_WR: begin
               if (!st_ff.open[b]) begin
                  nxt_st.refused = 1'b1;
                  nxt_st.pend = 1'b0;
               end else if (st_ff.rcd[b] == 4'h0
                            && st_ff.mrd == 4'h0) begin
                  nxt_st.cmd = st_ff.pendOp;
                  nxt_st.pend = 1'b0;
                  nxt_st.beatCnt = st_ff.countReg;
                  nxt_st.wrBurst = (st_ff.pendOp == CMD_WR);
                  nxt_st.dqOe = (st_ff.pendOp == CMD_WR);
                  if (st_ff.pendOp == CMD_RD) begin
                     nxt_st.capCnt = lat_cycles(st_ff.modeSh) + 3'h1;
                  end
               end
            end
            CMD_LMR: begin
               // Latency two at 25 MHz is well inside its clock limit
               if (st_ff.open != 4'h0
                   || !mode_legal(st_ff.addrReg)) begin
                  nxt_st.refused = 1'b1;
                  nxt_st.pend = 1'b0;
               end else if (st_ff.mrd == 4'h0) begin
                  nxt_st.cmd = CMD_LMR;
                  nxt_st.pend = 1'b0;
                  nxt_st.modeSh = st_ff.addrReg;
                  nxt_st.mrd = 4'(MRD_CYC - 1);
               end
            end
            CMD_PRE: begin
               if (st_ff.mrd == 4'h0) begin
                  nxt_st.cmd = CMD_PRE;
                  nxt_st.pend = 1'b0;
                  if (st_ff.addrReg[PRE_ALL_BIT]) nxt_st.open = 4'h0;
                  else nxt_st.open[b] = 1'b0;
               end
            end
            default: begin
               nxt_st.cmd = st_ff.pendOp;
               nxt_st.pend = 1'b0;
            end
         endcase
      end
   end

   //==========================================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.modeSh <= MODE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = !st_ff.awHave && !st_ff.bValid;
   assign s_axi_wready = !st_ff.wHave && !st_ff.bValid;
   assign s_axi_bvalid = st_ff.bValid;
   assign s_axi_bresp = st_ff.bResp;
   assign s_axi_arready = !st_ff.rValid;
   assign s_axi_rvalid = st_ff.rValid;
   assign s_axi_rdata = st_ff.rData;
   assign s_axi_rresp = st_ff.rResp;
   assign lk.cmd = st_ff.cmd;
   assign lk.bank = st_ff.bank;
   assign lk.addr = st_ff.addrOut;
   assign lk.ctrlDq = st_ff.wdataReg;
   assign lk.ctrlDqOe = st_ff.dqOe;

endmodule

// [src/sdb_device.sv]
// SDRAM device end: mode word, bank rows, burst sequencing, read pipe
`timescale 1ns/1ps
module sdb_device (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   sdb_link_if.dev                  lk,
   output      logic [1:0]          memBank,
   output      logic [10:0]         memRow,
   output      logic [7:0]          memCol,
   output      logic                memRd,
   output      logic                memWr,
   output      logic [31:0]         memWdata,
   input  wire logic [31:0]         memRdata,
   output      logic [3:0]          rowOpen,
   output      logic [12:0]         modeWord,
   output      logic                modeNormal
);
   import sdb_pkg::*;

   //==========================================================
   // State
   typedef struct packed {
      logic [12:0]       mode;
      logic [3:0]        rowOpen;
      logic [3:0][10:0]  openRow;
      logic              burstOn;
      logic              burstWr;
      logic [1:0]        bBank;
      logic [7:0]        bStart;
      logic [7:0]        bIdx;
      logic [8:0]        bLen;
      logic [1:0]        memBank;
      logic [10:0]       memRow;
      logic [7:0]        memCol;
      logic              memRd;
      logic              memWr;
      logic [31:0]       memWdata;
      logic              p1Val;
      logic [31:0]       p1Data;
      logic              dqVal;
      logic [31:0]       dqData;
   } sdb_dev_state_type;

   sdb_dev_state_type st_ff;
   sdb_dev_state_type nxt_st;

   //==========================================================
   // Burst decode
   // Length zero stands for a page burst that runs until stopped
   function automatic logic [8:0] burst_len(
      input logic [12:0] m,
      input logic        wr
   );
      logic [8:0] len;
      if (wr && m[SWR_BIT]) begin
         len = 9'h001;
      end else begin
         case (m[BL_LSB+:3])
            BL_1:    len = 9'h001;
            BL_2:    len = 9'h002;
            BL_4:    len = 9'h004;
            BL_8:    len = 9'h008;
            // Interleaved page is unsupported; it degrades to one word
            BL_PAGE: len = m[ORDER_BIT] ? 9'h001 : 9'h000;
            default: len = 9'h001;
         endcase
      end
      return len;
   endfunction

   function automatic logic [7:0] burst_col(
      input logic [7:0] start,
      input logic [7:0] idx,
      input logic [8:0] len,
      input logic       il
   );
      logic [7:0] mask;
      logic [7:0] off;
      mask = (len == 9'h000) ? 8'hFF : 8'(len - 9'h001);
      if (il) begin
         off = (start ^ idx) & mask;
      end else begin
         off = 8'(start + idx) & mask;
      end
      return (start & ~mask) | off;
   endfunction

   //==========================================================
   // Next state
   logic              normal;
   logic              doBeat;
   logic              beatWr;
   logic [1:0]        beatBank;
   logic [7:0]        beatCol;
   logic [8:0]        len;
   logic              stopBurst;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.memRd = 1'b0;
      nxt_st.memWr = 1'b0;
      doBeat = 1'b0;
      beatWr = st_ff.burstWr;
      beatBank = st_ff.bBank;
      beatCol = 8'h00;
      len = 9'h000;
      stopBurst = 1'b0;
      // Reserved operating modes leave reads and writes inert
      normal = (st_ff.mode[OPM_HI_BIT:OPM_LO_BIT] == 2'h0);

      // Read pipe: one stage for latency two, two stages for three
      nxt_st.p1Val = st_ff.memRd;
      nxt_st.p1Data = memRdata;
      if (lat_cycles(st_ff.mode) == 3'h3) begin
         nxt_st.dqVal = st_ff.p1Val;
         nxt_st.dqData = st_ff.p1Data;
      end else begin
         nxt_st.dqVal = st_ff.memRd;
         nxt_st.dqData = memRdata;
      end

      case (lk.cmd)
         CMD_ACT: begin
            nxt_st.rowOpen[lk.bank] = 1'b1;
            nxt_st.openRow[lk.bank] = lk.addr[10:0];
         end
         CMD_PRE: begin
            if (lk.addr[PRE_ALL_BIT]) begin
               nxt_st.rowOpen = 4'h0;
               stopBurst = 1'b1;
            end else begin
               nxt_st.rowOpen[lk.bank] = 1'b0;
               stopBurst = (lk.bank == st_ff.bBank);
            end
         end
         CMD_BST: begin
            stopBurst = 1'b1;
         end
         CMD_RD, CMD_WR: begin
            stopBurst = 1'b1;
         end
         CMD_LMR: begin
            // Only honoured with every bank idle
            if (st_ff.rowOpen == 4'h0) begin
               nxt_st.mode = lk.addr;
            end
         end
         default: begin
         end
      endcase

      // Running burst advances one column per clock
      if (st_ff.burstOn && !stopBurst) begin
         doBeat = 1'b1;
         beatCol = burst_col(st_ff.bStart, st_ff.bIdx, st_ff.bLen,
                             st_ff.mode[ORDER_BIT]);
         nxt_st.bIdx = st_ff.bIdx + 8'h01;
         if (st_ff.bLen != 9'h000
             && {1'b0, st_ff.bIdx} + 9'h001 == st_ff.bLen) begin
            nxt_st.burstOn = 1'b0;
         end
      end else if (stopBurst) begin
         nxt_st.burstOn = 1'b0;
      end

      // A new read or write truncates any running burst
      if ((lk.cmd == CMD_RD || lk.cmd == CMD_WR)
          && st_ff.rowOpen[lk.bank] && normal) begin
         beatWr = (lk.cmd == CMD_WR);
         beatBank = lk.bank;
         len = burst_len(st_ff.mode, beatWr);
         doBeat = 1'b1;
         beatCol = burst_col(lk.addr[7:0], 8'h00, len,
                             st_ff.mode[ORDER_BIT]);
         nxt_st.burstOn = (len != 9'h001);
         nxt_st.burstWr = beatWr;
         nxt_st.bBank = lk.bank;
         nxt_st.bStart = lk.addr[7:0];
         nxt_st.bIdx = 8'h01;
         nxt_st.bLen = len;
      end

      //=======================================================
      // Storage access for this beat
      if (doBeat) begin
         nxt_st.memBank = beatBank;
         nxt_st.memRow = st_ff.openRow[beatBank];
         nxt_st.memCol = beatCol;
         nxt_st.memRd = !beatWr;
         // Write data is taken on the same edge as its column
         nxt_st.memWr = beatWr && lk.ctrlDqOe;
         nxt_st.memWdata = lk.ctrlDq;
      end
   end

   //==========================================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.mode <= MODE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   //==========================================================
   // Outputs
   assign lk.devDq = st_ff.dqData;
   assign lk.devDqOe = st_ff.dqVal;
   assign memBank = st_ff.memBank;
   assign memRow = st_ff.memRow;
   assign memCol = st_ff.memCol;
   assign memRd = st_ff.memRd;
   assign memWr = st_ff.memWr;
   assign memWdata = st_ff.memWdata;
   assign rowOpen = st_ff.rowOpen;
   assign modeWord = st_ff.mode;
   assign modeNormal = (st_ff.mode[OPM_HI_BIT:OPM_LO_BIT] == 2'h0);

endmodule

// [src/sdb_link_if.sv]
// Command, address and data link between controller and SDRAM
`timescale 1ns/1ps
interface sdb_link_if;
   import sdb_pkg::*;
   sdb_cmd_type        cmd;
   logic [1:0]         bank;
   logic [12:0]        addr;
   logic [31:0]        ctrlDq;
   logic               ctrlDqOe;
   logic [31:0]        devDq;
   logic               devDqOe;
   modport ctrl (
      output cmd,
      output bank,
      output addr,
      output ctrlDq,
      output ctrlDqOe,
      input  devDq,
      input  devDqOe
   );
   modport dev (
      input  cmd,
      input  bank,
      input  addr,
      input  ctrlDq,
      input  ctrlDqOe,
      output devDq,
      output devDqOe
   );
endinterface

// [src/sdb_pkg.sv]
// Shared constants, types and helpers for the SDRAM burst link
//=============================================================
// Behaviour
// - Lengths 1,2,4,8 both orders; page sequential only
// - Controller ends page bursts with burst stop
// - Burst stays in aligned block, wraps inside
// - Low column bits pick first location
// - Page burst wraps across 256 columns until stopped
// - Bit three selects sequential or interleaved
// - Sequential offset adds one modulo length
// - Interleaved offset is start xor index
// - Read latency two or three clocks
// - Drive after n+m-1, data by n+m
// - Latency two only up to 133 MHz
// - Operating mode bits must both be zero
// - Single write bit makes writes one location
// - Controller never loads reserved mode codes
// - Activate a row before reading or writing
// - Wait activate-to-column delay, rounded up
// - Precharge before new row; respect row cycle
// - Space activates to different banks
// - Length bits 0-2, latency 4-6, 10-12 reserved
// - Load mode only with all banks idle
package sdb_pkg;
   //==========================================================
   // Geometry
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 13;
   localparam int ROW_W   = 11;
   localparam int COL_W   = 8;
   localparam int BANK_W  = 2;
   localparam int BANKS   = 4;
   localparam int PRE_ALL_BIT = 10;
   //==========================================================
   // Mode word layout
   localparam int BL_LSB      = 0;
   localparam int ORDER_BIT   = 3;
   localparam int LAT_LSB     = 4;
   localparam int OPM_LO_BIT  = 7;
   localparam int OPM_HI_BIT  = 8;
   localparam int SWR_BIT     = 9;
   localparam int RSV_LSB     = 10;
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam logic [2:0] LAT_2   = 3'h2;
   localparam logic [2:0] LAT_3   = 3'h3;
   localparam logic [12:0] MODE_RST = 13'h0020;
   //==========================================================
   // Timing at 25 MHz
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_RCD_NS      = 20;
   localparam int T_RC_NS       = 60;
   localparam int T_RRD_NS      = 12;
   localparam int MRD_CYC       = 2;
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int RCD_CYC = cyc_up(T_RCD_NS);
   localparam int RC_CYC  = cyc_up(T_RC_NS);
   localparam int RRD_CYC = cyc_up(T_RRD_NS);
   //==========================================================
   // Controller register map
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_COUNT  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA  = 8'h14;
   localparam logic [7:0] REG_MODE   = 8'h18;
   localparam int CMD_BANK_LSB = 4;
   localparam int ST_BUSY      = 0;
   localparam int ST_REFUSED   = 1;
   localparam int ST_RDVALID   = 2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   //==========================================================
   // Link commands
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_LMR
   } sdb_cmd_type;
   //==========================================================
   // Helpers
   function automatic logic [2:0] lat_cycles(input logic [12:0] m);
      return (m[LAT_LSB+:3] == LAT_3) ? 3'h3 : 3'h2;
   endfunction
   function automatic logic mode_legal(input logic [12:0] m);
      logic okLen;
      logic okLat;
      okLen = (m[BL_LSB+:3] <= BL_8)
            || (m[BL_LSB+:3] == BL_PAGE && !m[ORDER_BIT]);
      okLat = (m[LAT_LSB+:3] == LAT_2) || (m[LAT_LSB+:3] == LAT_3);
      return okLen && okLat && (m[OPM_HI_BIT:OPM_LO_BIT] == 2'h0)
             && (m[12:RSV_LSB] == 3'h0);
   endfunction
endpackage
